// File: hcec_map.vh
// Constants and field values for the in-line frame CRC block.
// What this block does
// - Enable and mode pick pass, generate, check.
// - Accumulate after opening flag, skip stuffed zeros.
// - Generate: hold clock, send inverted stuffed CRC.
// - Check: error output one bit after flag.
// - Message valid only from sixteen significant bits.
// - Stuffed zeros never count toward length.
// - Short message passes through untouched.
// - Bit-16 missing stuffing: too short, restart.
// - Bit-17 case: forward bit, exclude from CRC.
// - Bit-17 case: first CRC bit sent zero.
// - Check mode bit-17 case: exclude bit.
// - After missing stuffing keep hunting flag, abort.
// - Abort abandons message and its check.
// - Check mode: flag after missing stuffing past bit 17 reports error.
// - Missing stuffing then zero: strip, continue.
`ifndef HCEC_MAP_VH
`define HCEC_MAP_VH
// Preset loaded into the accumulator at each flag.
`define HCEC_CRC_PRESET 16'hFFFF
// Reflected generator polynomial, bits enter least significant first.
`define HCEC_CRC_POLY 16'h8408
// Remainder left in the accumulator by a good frame with its check field.
`define HCEC_CRC_GOOD 16'hF0B8
// Number of check bits shifted out.
`define HCEC_CRC_BITS 5'h10
// Least number of significant bits in a message.
`define HCEC_MIN_LEN 5'h10
// Ceiling of the significant-bit counter.
`define HCEC_CNT_SAT 5'h12
// Run of ones after which a zero is stuffing.
`define HCEC_ONES_STUFF 3'h5
// Run of ones that a zero turns into a flag.
`define HCEC_ONES_FLAG 3'h6
// Run of ones that is an abort.
`define HCEC_ONES_ABORT 3'h7
// Depth of the input FIFO.
`define HCEC_FIFO_DEPTH 8
// Width of the input FIFO words.
`define HCEC_FIFO_WIDTH 1
`endif

// File: hcec_core.v
// Input FIFO and the serial CRC generate and check engine.
`timescale 1ns/1ps
`include "hcec_map.vh"

// Small FIFO of flip-flops with valid and ready on both sides.
module hcec_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage words.
  reg [AW-1:0] wr_q; // Write index.
  reg [AW-1:0] rd_q; // Read index.
  reg [AW:0] cnt_q; // Words held.
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the depth; the count gives honest full and empty.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// Serial engine: flag, stuffing and abort hunting, CRC and output stuffing.
module hcec_core (
  input wire clk,
  input wire reset_n,
  input wire bit_clock_input,
  input wire serial_data_input,
  output wire serial_in_ready,
  input wire crc_enable_input,
  input wire crc_mode_select,
  output reg serial_data_output,
  output reg gated_clock_output,
  output reg crc_error_output
);
  wire fifo_valid; // A received bit waits.
  wire fifo_bit; // The waiting bit.
  wire take; // A received bit is processed this cycle.
  reg [7:0] dly_q; // Delay line of received bits, bit 7 oldest.
  reg [7:0] sig_q; // Significance tags that travel with the bits.
  reg [2:0] ones_q; // Run of ones on the input side.
  reg strip_q; // The latest zero was taken as stuffing.
  reg acc_q; // A message is being accumulated.
  reg [15:0] crc_q; // Accumulator.
  reg [15:0] crc_prev_q; // Accumulator before its latest update.
  reg [4:0] cnt_q; // Significant bits seen in the message.
  reg send_q; // Check field is being shifted out.
  reg [15:0] sh_q; // Check field still to send.
  reg [4:0] left_q; // Check bits still to send.
  reg [2:0] tx_ones_q; // Run of ones on the output side.
  reg err_pend_q; // Check verdict waiting for the next bit edge.
  reg err_eval_q; // A verdict is waiting.
  reg [15:0] crc_d;
  reg [15:0] prev_d;
  reg [4:0] cnt_d;
  reg [4:0] len_d;
  reg exit_sig;
  reg is_flag;
  reg is_abort;
  reg is_stuff;
  reg miss;
  reg out_bit;

  // Advance a reflected CRC by one bit.
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
      crc_step = {1'b0, c[15:1]} ^ (((c[0] ^ b) == 1'b1) ? `HCEC_CRC_POLY : 16'h0000);
    end
  endfunction

  // Next run length of ones for an emitted or received bit.
  function [2:0] run_next;
    input [2:0] r;
    input b;
    begin
      run_next = b ? ((r == `HCEC_ONES_ABORT) ? r : r + 3'h1) : 3'h0;
    end
  endfunction

  // Input bits are held in the FIFO while the check field goes out.
  hcec_fifo #(
    .WIDTH(`HCEC_FIFO_WIDTH),
    .DEPTH(`HCEC_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(bit_clock_input),
    .in_ready(serial_in_ready),
    .in_data(serial_data_input),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_bit)
  );

  assign take = bit_clock_input && fifo_valid && !send_q;

  // Classify the incoming bit and fold the leaving bit into the accumulator.
  always @* begin
    is_stuff = !fifo_bit && (ones_q == `HCEC_ONES_STUFF);
    is_flag = !fifo_bit && (ones_q == `HCEC_ONES_FLAG);
    is_abort = fifo_bit && (ones_q == `HCEC_ONES_FLAG);
    exit_sig = sig_q[7] && acc_q && crc_enable_input;
    crc_d = exit_sig ? crc_step(crc_q, dly_q[7]) : crc_q;
    prev_d = exit_sig ? crc_q : crc_prev_q;
    cnt_d = (exit_sig && cnt_q != `HCEC_CNT_SAT) ? cnt_q + 5'h1 : cnt_q;
    // The flag's own zero was eaten as stuffing: the last one had no stuffing.
    miss = strip_q;
    len_d = (miss && cnt_d != 5'h00) ? cnt_d - 5'h1 : cnt_d;
    out_bit = (tx_ones_q == `HCEC_ONES_STUFF) ? 1'b0 : sh_q[0];
  end

  // Main sequence, one step per bit strobe.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_q <= 8'h00;
      sig_q <= 8'h00;
      ones_q <= 3'h0;
      strip_q <= 1'b0;
      acc_q <= 1'b0;
      crc_q <= `HCEC_CRC_PRESET;
      crc_prev_q <= `HCEC_CRC_PRESET;
      cnt_q <= 5'h00;
      send_q <= 1'b0;
      sh_q <= 16'h0000;
      left_q <= 5'h00;
      tx_ones_q <= 3'h0;
      err_pend_q <= 1'b0;
      err_eval_q <= 1'b0;
      serial_data_output <= 1'b0;
      gated_clock_output <= 1'b0;
      crc_error_output <= 1'b0;
    end else begin
      // The receiver clock is held high while the check field leaves.
      gated_clock_output <= send_q ? 1'b1 : bit_clock_input;
      if (!crc_enable_input) begin
        acc_q <= 1'b0;
      end
      if (bit_clock_input && err_eval_q) begin
        // The verdict shows on the bit edge after the flag entered.
        crc_error_output <= err_pend_q;
        err_eval_q <= 1'b0;
      end
      if (bit_clock_input && send_q) begin
        // Send the check field, stuffing a zero after five ones.
        serial_data_output <= out_bit;
        tx_ones_q <= run_next(tx_ones_q, out_bit);
        if (tx_ones_q != `HCEC_ONES_STUFF) begin
          sh_q <= {1'b0, sh_q[15:1]};
          left_q <= left_q - 5'h1;
        end
        if (left_q == 5'h00 || (left_q == 5'h01 && tx_ones_q != `HCEC_ONES_STUFF &&
            !(sh_q[0] && tx_ones_q == 3'h4))) begin
          send_q <= 1'b0;
        end
      end else if (take) begin
        serial_data_output <= dly_q[7];
        tx_ones_q <= run_next(tx_ones_q, dly_q[7]);
        dly_q <= {dly_q[6:0], fifo_bit};
        ones_q <= run_next(ones_q, fifo_bit);
        if (!fifo_bit) begin
          strip_q <= is_stuff;
        end
        crc_q <= crc_d;
        crc_prev_q <= prev_d;
        cnt_q <= cnt_d;
        if (is_flag) begin
          // Flag bits never enter the accumulator; a fresh message begins.
          sig_q <= 8'h00;
          crc_q <= `HCEC_CRC_PRESET;
          crc_prev_q <= `HCEC_CRC_PRESET;
          cnt_q <= 5'h00;
          acc_q <= crc_enable_input;
          if (acc_q && crc_enable_input && len_d >= `HCEC_MIN_LEN) begin
            if (!crc_mode_select) begin
              // Inverted check field; in the bit-17 case the last one is left out.
              sh_q <= ~(miss ? prev_d : crc_d);
              left_q <= `HCEC_CRC_BITS;
              send_q <= 1'b1;
            end else begin
              err_pend_q <= ((miss ? prev_d : crc_d) != `HCEC_CRC_GOOD) ||
                            (miss && cnt_d > 5'h11);
              err_eval_q <= 1'b1;
            end
          end
        end else if (ones_q == `HCEC_ONES_FLAG && fifo_bit) begin
          // Seventh one: abort, nothing more is accumulated.
          sig_q <= 8'h00;
          acc_q <= 1'b0;
        end else begin
          sig_q <= {sig_q[6:0], acc_q && crc_enable_input && !is_stuff && !is_abort};
        end
      end
    end
  end
endmodule

// File: hcec_sva.sv
// Port checker for the frame CRC block.
`timescale 1ns/1ps
module hcec_sva (
  input wire clk,
  input wire reset_n,
  input wire bit_clock_input,
  input wire serial_data_input,
  input wire serial_in_ready,
  input wire crc_enable_input,
  input wire crc_mode_select,
  input wire serial_data_output,
  input wire gated_clock_output,
  input wire crc_error_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // No bit time starts in this cycle.
  sequence s_quiet;
    !bit_clock_input;
  endsequence
  // Pass-through selected for two cycles.
  sequence s_pass;
    !crc_enable_input [*2];
  endsequence
  chk_gate_follow: assert property (bit_clock_input |=> gated_clock_output)
    else $error("gated clock missed a strobe");
  chk_out_hold: assert property (s_quiet |=> $stable(serial_data_output))
    else $error("output moved without a strobe");
  chk_err_hold: assert property (s_quiet |=> $stable(crc_error_output))
    else $error("error moved without a strobe");
  chk_force_gen: assert property (gated_clock_output && !$past(bit_clock_input)
    |-> crc_enable_input && !crc_mode_select) else $error("clock held outside generate");
  chk_pass_err: assert property (s_pass |=> $stable(crc_error_output))
    else $error("error moved in pass-through");
  chk_err_mode: assert property ($rose(crc_error_output) |-> crc_mode_select)
    else $error("error raised outside check mode");
  chk_pass_gate: assert property (s_pass ##0 s_quiet |=> !gated_clock_output)
    else $error("clock held in pass-through");
  chk_gen_noerr: assert property (!crc_mode_select [*2] |=> $stable(crc_error_output))
    else $error("error moved in generate mode");
endmodule
bind hcec_core hcec_sva hcec_sva_inst (.clk(clk), .reset_n(reset_n),
  .bit_clock_input(bit_clock_input), .serial_data_input(serial_data_input),
  .serial_in_ready(serial_in_ready), .crc_enable_input(crc_enable_input),
  .crc_mode_select(crc_mode_select), .serial_data_output(serial_data_output),
  .gated_clock_output(gated_clock_output), .crc_error_output(crc_error_output));

// File: hcec_line.sv
// Serial line model that strobes frame bits into the block.
`timescale 1ns/1ps
module hcec_line (
  input wire clk,
  output logic strobe = 1'b0,
  output logic data = 1'b0
);
  // One bit per gap+1 clocks; between bits the line shows the inverse.
  task send(input bit q[$], input int gap);
    foreach (q[i]) begin
      strobe = 1'b1;
      data = q[i];
      @(posedge clk) #1;
      if (gap > 0) begin
        strobe = 1'b0;
        data = ~q[i];
        repeat (gap) @(posedge clk) #1;
      end
    end
    strobe = 1'b0;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the frame CRC block.
`timescale 1ns/1ps
`include "hcec_map.vh"
module tb_top;
  logic clk, reset_n, crc_enable_input, crc_mode_select;
  wire bit_clock_input, serial_data_input, serial_in_ready;
  wire serial_data_output, gated_clock_output, crc_error_output;
  int num_errors = 0;
  int checks = 0;
  int ones = 0;
  // Cycles in which the gated clock stood high with no strobe just before it.
  int held = 0;
  bit fr[$], hist[$], cap[$];
  // Strobe seen at the previous clock edge.
  bit pst;
  bit cmp_on, cap_on, saw_full;
  bit [7:0] fl = 8'h7E;
  logic [15:0] c;
  hcec_line hcec_line_inst (.clk(clk), .strobe(bit_clock_input), .data(serial_data_input));
  hcec_core hcec_core_inst (.clk(clk), .reset_n(reset_n),
    .bit_clock_input(bit_clock_input), .serial_data_input(serial_data_input),
    .serial_in_ready(serial_in_ready), .crc_enable_input(crc_enable_input),
    .crc_mode_select(crc_mode_select), .serial_data_output(serial_data_output),
    .gated_clock_output(gated_clock_output), .crc_error_output(crc_error_output));
  task check(string nm, logic e, logic s);
    checks++;
    if (e !== s) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task results;
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Queues a line bit; st adds a stuffed zero after five ones.
  task put(bit b, bit st);
    fr.push_back(b);
    ones = b ? ones + 1 : 0;
    if (st && ones == 5) begin
      fr.push_back(1'b0);
      ones = 0;
    end
  endtask
  // Message bit that also feeds the model CRC, first bit lowest.
  task raw(bit b, bit st);
    put(b, st);
    c = (c >> 1) ^ ((c[0] ^ b) ? `HCEC_CRC_POLY : 16'h0000);
  endtask
  task dat(int n);
    repeat (n) raw(1'($urandom), 1'b1);
  endtask
  task flag;
    for (int i = 0; i < 8; i++) fr.push_back(fl[i]);
    ones = 0;
    c = `HCEC_CRC_PRESET;
  endtask
  // A zero, then five or seven ones with their stuffed zero missing.
  task miss(int n);
    put(1'b0, 1'b0);
    repeat (n) put(1'b1, 1'b0);
  endtask
  // Appends the inverted model CRC, stuffed, with bit 0 flipped when bad is set.
  task tail(bit bad);
    logic [15:0] k;
    k = ~c ^ {15'h0000, bad};
    for (int i = 0; i < 16; i++) put(k[i], 1'b1);
  endtask
  task good(bit bad);
    flag;
    dat(24);
    tail(bad);
  endtask
  task go(int gap);
    hcec_line_inst.send(fr, gap);
    fr.delete();
    repeat (4) @(posedge clk) #1;
  endtask
  // Closes the frame, flushes the verdict and compares it.
  task run(bit e);
    flag;
    flag;
    go(0);
    check("crc_error_output", e, crc_error_output);
  endtask
  // Delay line model in pass-through, and capture of generated output.
  always @(posedge clk) begin
    if (bit_clock_input) begin
      if (cmp_on && hist.size() >= 10)
        check("serial_data_output", hist[hist.size() - 10], serial_data_output);
      hist.push_back(serial_data_input);
      if (cap_on) cap.push_back(serial_data_output);
    end
    if (cap_on && !serial_in_ready) saw_full = 1'b1;
    // Outside the check field the gated clock is high only just after a strobe.
    if (cap_on && gated_clock_output && !pst) held++;
    pst <= bit_clock_input;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    num_errors++;
    results;
  end
  initial begin
    reset_n = 1'b0;
    crc_enable_input = 1'b0;
    crc_mode_select = 1'b1;
    void'($urandom(39637));
    repeat (10) @(posedge clk) #1;
    reset_n = 1'b1;
    cmp_on = 1'b1;
    flag;
    repeat (80) put(1'($urandom), 1'b0);
    go(2);
    cmp_on = 1'b0;
    crc_enable_input = 1'b1;
    good(0);
    run(0);
    good(1);
    run(1);
    good(0);
    flag;
    repeat (15) raw(1'b1, 1'b1);
    run(0);
    flag;
    dat(10);
    miss(5);
    run(0);
    good(0);
    miss(5);
    run(1);
    good(0);
    run(0);
    flag;
    dat(20);
    raw(1'b0, 1'b0);
    repeat (5) raw(1'b1, 1'b0);
    raw(1'b0, 1'b0);
    dat(8);
    tail(1'b0);
    run(1);
    good(0);
    run(0);
    flag;
    dat(20);
    miss(7);
    run(0);
    crc_mode_select = 1'b0;
    cap_on = 1'b1;
    flag;
    dat(24);
    flag;
    repeat (32) put(1'b0, 1'b0);
    go(2);
    cap_on = 1'b0;
    check("saw_full", 1'b1, saw_full);
    check("gated_hold", 1'b1, held >= 32);
    reset_n = 1'b0;
    @(posedge clk) #1;
    reset_n = 1'b1;
    crc_mode_select = 1'b1;
    // A failing frame first, so that only a fresh verdict on the loop-back clears the error.
    good(1);
    flag;
    fr = {fr, cap};
    run(0);
    results;
  end
endmodule
